// File: rtl/output_enable_header_filter.sv
// output-enable header filter with Avalon-MM register slave
// assumes front-end pins are asynchronous and a single 20 MHz clock
//
// How it works
// - data output stays off until a valid header arrives, then opens
// - high select 01/10/11 gives 1/2/4 ms; low select 00,01/10/11 gives 1/2/4 ms
// - maximum period table: 3,4,6 / 4,5,8 / 6,8,10 ms
// - high select 00 bypasses the filter and passes all data
// - high pulse timed rise to fall, must lie between minimum and maximum
// - low pulse timed fall to rise, must lie between minimum and maximum
// - any failure restarts the filter for a fresh high then low
// - carrier loss over 56 us during the high pulse resets the filter
// - soft reset command returns the filter to its waiting state
// - after an overlong high, wait a restart gap then a new rise
// - evaluation starts right after the gap following AGC settling
// - status bit 5 shows the AGC regulating
// - gate bit 7 hides data and carrier until AGC regulates
// - configuration register 0 bits 3 to 1 enable each channel
// - disabled channel powers down its path, limiter stays on
// - per-channel gain reduction settings from 0 dB to about -30 dB
// - AGC settling holds filter 3.5 ms; no signal at end aborts
// - 32 ms signal without passing raises alarm; off when bypassed
`timescale 1ns/10ps
`include "oef_cfg.svh"
module output_enable_header_filter (
  input wire logic clock_in,
  input wire logic rst_b_in,
  input wire logic [4:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire oef_pkg::fe_pins_t fe_in,
  input wire logic soft_reset_cmd_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  output logic demod_data_out,
  output logic carrier_out,
  output logic alert_b_out,
  output logic [2:0] chan_power_out,
  output logic [11:0] gain_red_out
);
  import oef_pkg::*;

  localparam int TW = 10;
  localparam logic [TW-1:0] AGC_LAST = TW'(`OEF_AGC_TICKS - 1);
  localparam logic [TW-1:0] GAP_LAST = TW'(`OEF_GAP_TICKS - 1);
  localparam logic [TW-1:0] RESTART_LAST = TW'(`OEF_RESTART_TICKS - 1);
  localparam logic [TW:0] ALARM_LAST = (TW+1)'(`OEF_ALARM_TICKS - 1);
  localparam logic [10:0] DROP_LIMIT = 11'(`OEF_DROP_CYCLES);
  localparam logic [TW-1:0] TICKS_MS = TW'(`OEF_TICKS_PER_MS);

  // ------------------------------------------------------------
  // time tables
  // ------------------------------------------------------------
  // scale whole milliseconds into filter ticks
  function automatic logic [TW-1:0] ms_ticks(input logic [3:0] ms);
    ms_ticks = TW'(ms * TICKS_MS);
  endfunction

  // select code to 1, 2 or 4 ms; code 00 reads as 1 ms for the low side
  function automatic logic [3:0] sel_ms(input logic [1:0] sel);
    case (sel)
      2'b10: sel_ms = 4'h2;
      2'b11: sel_ms = 4'h4;
      default: sel_ms = 4'h1;
    endcase
  endfunction

  // maximum period: one ms of slack over high plus low, two once that sum reaches 6 ms
  function automatic logic [3:0] max_ms(input logic [1:0] h, input logic [1:0] l);
    logic [3:0] base;
    base = sel_ms(h) + sel_ms(l);
    max_ms = base + 4'h1 + ((base >= 4'h6) ? 4'h1 : 4'h0);
  endfunction

  // ------------------------------------------------------------
  // input synchronisers
  // ------------------------------------------------------------
  fe_pins_t sync1;
  fe_pins_t pins;
  fe_pins_t pins_d;

  // two stages before any logic looks at the front-end levels
  always_ff @(posedge clock_in) begin
    if (!rst_b_in) begin
      sync1 <= '0;
      pins <= '0;
      pins_d <= '0;
    end else begin
      sync1 <= fe_in;
      pins <= sync1;
      pins_d <= pins;
    end
  end

  wire demod_rise = pins.demod && !pins_d.demod;
  wire demod_fall = !pins.demod && pins_d.demod;
  wire carrier_edge = pins.carrier ^ pins_d.carrier;

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  logic [8:0] cfg0;
  logic cfg1_gate;
  logic [11:0] gain;
  oef_cfg_t cfg;

  assign cfg.high_time_sel = cfg0[`OEF_HSEL_LSB +: 2];
  assign cfg.low_time_sel = cfg0[`OEF_LSEL_LSB +: 2];
  assign cfg.chan_en = cfg0[`OEF_CHEN_LSB +: 3];
  assign cfg.strong_signal_gate = cfg1_gate;
  assign cfg.gain_red = gain;

  // ------------------------------------------------------------
  // bus slave
  // ------------------------------------------------------------
  // one wait state: waitrequest drops the cycle after a request is seen
  wire bus_req = avs_read_in || avs_write_in;
  wire bus_done = bus_req && !avs_waitrequest_out;
  wire next_wait = !(bus_req && avs_waitrequest_out);
  wire wr_cfg0 = bus_done && avs_write_in && (avs_address_in == `OEF_ADDR_CFG0);
  wire wr_cfg1 = bus_done && avs_write_in && (avs_address_in == `OEF_ADDR_CFG1);
  wire wr_gain = bus_done && avs_write_in && (avs_address_in == `OEF_ADDR_GAIN);
  wire wr_ctrl = bus_done && avs_write_in && (avs_address_in == `OEF_ADDR_CTRL);
  wire soft_reset = soft_reset_cmd_in || (wr_ctrl && avs_writedata_in[`OEF_CTRL_SRST_BIT]);

  logic [31:0] status_word;
  logic [31:0] rd_mux;

  // unmapped addresses read zero and ignore writes
  always_comb begin
    if (avs_address_in == `OEF_ADDR_CFG0) begin
      rd_mux = 32'(cfg0);
    end else if (avs_address_in == `OEF_ADDR_CFG1) begin
      rd_mux = 32'(cfg1_gate) << `OEF_GATE_BIT;
    end else if (avs_address_in == `OEF_ADDR_GAIN) begin
      rd_mux = 32'(gain);
    end else if (avs_address_in == `OEF_ADDR_STATUS) begin
      rd_mux = status_word;
    end else begin
      rd_mux = 32'h0000_0000;
    end
  end

  // configuration survives soft reset; only a hard reset clears it
  always_ff @(posedge clock_in) begin
    if (!rst_b_in) begin
      cfg0 <= `OEF_CFG0_RESET;
      cfg1_gate <= `OEF_CFG1_RESET;
      gain <= `OEF_GAIN_RESET;
      avs_waitrequest_out <= 1'b1;
      avs_readdata_out <= 32'h0000_0000;
    end else begin
      avs_waitrequest_out <= next_wait;
      if (avs_read_in && avs_waitrequest_out) begin
        avs_readdata_out <= rd_mux;
      end
      if (wr_cfg0) begin
        cfg0 <= avs_writedata_in[8:0];
      end
      if (wr_cfg1) begin
        cfg1_gate <= avs_writedata_in[`OEF_GATE_BIT];
      end
      if (wr_gain) begin
        gain <= avs_writedata_in[11:0];
      end
    end
  end

  // ------------------------------------------------------------
  // time base
  // ------------------------------------------------------------
  logic tick;

  rc_tick_gen #(
    .DIV(`OEF_DIV_CYCLES)
  ) u_tick (
    .clock_in(clock_in),
    .rst_b_in(rst_b_in),
    .restart_in(soft_reset),
    .tick_out(tick)
  );

  // ------------------------------------------------------------
  // thresholds
  // ------------------------------------------------------------
  wire bypass = (cfg.high_time_sel == 2'b00);
  wire [TW-1:0] min_high = ms_ticks(sel_ms(cfg.high_time_sel));
  wire [TW-1:0] min_low = ms_ticks(sel_ms(cfg.low_time_sel));
  wire [TW-1:0] max_period = ms_ticks(max_ms(cfg.high_time_sel, cfg.low_time_sel));

  // ------------------------------------------------------------
  // filter sequencer
  // ------------------------------------------------------------
  filt_state_t state;
  filt_state_t next_state;
  logic [TW-1:0] cnt;
  logic [TW-1:0] next_cnt;
  logic [TW-1:0] lo_cnt;
  logic [TW-1:0] next_lo_cnt;
  logic [10:0] drop_cnt;
  logic abort;

  wire [TW-1:0] cnt_inc = (tick && cnt != '1) ? cnt + TW'(1) : cnt;
  wire [TW-1:0] lo_inc = (tick && lo_cnt != '1) ? lo_cnt + TW'(1) : lo_cnt;
  wire [TW:0] period = {1'b0, cnt} + {1'b0, lo_cnt};
  wire carrier_lost = (drop_cnt >= DROP_LIMIT);

  // counters restart on state entry, but low keeps the high count so the period spans high plus low
  always_comb begin
    next_state = state;
    next_cnt = cnt_inc;
    next_lo_cnt = lo_cnt;
    abort = 1'b0;
    case (state)
      ST_STANDBY: begin
        next_cnt = '0;
        if (pins.demod) begin
          next_state = ST_AGC;
        end
      end
      ST_AGC: begin
        if (tick && cnt == AGC_LAST) begin
          next_cnt = '0;
          if (pins.demod) begin
            next_state = ST_GAP;
          end else begin
            abort = 1'b1;
            next_state = ST_STANDBY;
          end
        end
      end
      ST_GAP: begin
        if (tick && cnt == GAP_LAST) begin
          next_cnt = '0;
          next_state = bypass ? ST_OPEN : ST_ARM;
        end
      end
      ST_ARM: begin
        next_cnt = '0;
        if (bypass) begin
          next_state = ST_OPEN;
        end else if (demod_rise) begin
          next_state = ST_HIGH;
        end
      end
      ST_HIGH: begin
        next_lo_cnt = '0;
        if (bypass) begin
          next_state = ST_OPEN;
        end else if (cnt > max_period) begin
          next_cnt = '0;
          next_state = ST_HOLDOFF;
        end else if (carrier_lost) begin
          next_state = ST_ARM;
        end else if (demod_fall) begin
          next_cnt = cnt;
          next_state = (cnt >= min_high) ? ST_LOW : ST_ARM;
        end
      end
      ST_LOW: begin
        next_cnt = cnt;
        next_lo_cnt = lo_inc;
        if (bypass) begin
          next_state = ST_OPEN;
        end else if (period > {1'b0, max_period}) begin
          next_state = ST_ARM;
        end else if (demod_rise) begin
          if (lo_cnt >= min_low) begin
            next_state = ST_OPEN;
          end else begin
            next_cnt = '0;
            next_state = ST_HIGH;
          end
        end
      end
      ST_HOLDOFF: begin
        if (tick && cnt == RESTART_LAST) begin
          next_cnt = '0;
          next_state = ST_ARM;
        end
      end
      ST_OPEN: begin
        next_cnt = '0;
      end
      default: begin
        next_state = ST_STANDBY;
      end
    endcase
  end

  always_ff @(posedge clock_in) begin
    if (!rst_b_in || soft_reset) begin
      state <= ST_STANDBY;
      cnt <= '0;
      lo_cnt <= '0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      lo_cnt <= next_lo_cnt;
    end
  end

  // carrier dropout timer, counted in 50 ns system cycles to resolve the 56 us limit
  always_ff @(posedge clock_in) begin
    if (!rst_b_in || state != ST_HIGH || carrier_edge) begin
      drop_cnt <= '0;
    end else if (!carrier_lost) begin
      drop_cnt <= drop_cnt + 11'd1;
    end
  end

  // ------------------------------------------------------------
  // alarm timer
  // ------------------------------------------------------------
  logic [TW:0] alarm_cnt;
  logic alarm;
  wire checking = (state == ST_ARM) || (state == ST_HIGH) || (state == ST_LOW) || (state == ST_HOLDOFF);
  wire alarm_hit = tick && checking && !bypass && (alarm_cnt == ALARM_LAST);
  wire alarm_clr = bus_done || bypass || (state == ST_OPEN) || abort;

  // a bus access stands in for chip select; a hit in the same cycle wins
  always_ff @(posedge clock_in) begin
    if (!rst_b_in || soft_reset) begin
      alarm_cnt <= '0;
      alarm <= 1'b0;
    end else begin
      if (alarm_clr || !checking) begin
        alarm_cnt <= '0;
      end else if (tick && alarm_cnt != ALARM_LAST) begin
        alarm_cnt <= alarm_cnt + (TW+1)'(1);
      end
      if (alarm_hit) begin
        alarm <= 1'b1;
      end else if (alarm_clr) begin
        alarm <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // status
  // ------------------------------------------------------------
  always_comb begin
    status_word = 32'h0000_0000;
    status_word[`OEF_ST_ALARM_BIT] = alarm;
    status_word[`OEF_ST_OPEN_BIT] = (state == ST_OPEN);
    status_word[`OEF_ST_AGCF_BIT] = pins.agc;
    status_word[`OEF_ST_STATE_LSB +: 3] = state;
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  // with the gate set a weak field never reaches the microcontroller
  wire gate_ok = !cfg.strong_signal_gate || pins.agc;
  wire data_open = (state == ST_OPEN);

  always_ff @(posedge clock_in) begin
    if (!rst_b_in) begin
      demod_data_out <= 1'b0;
      carrier_out <= 1'b0;
      alert_b_out <= 1'b1;
      chan_power_out <= 3'h0;
      gain_red_out <= 12'h000;
    end else begin
      demod_data_out <= data_open && gate_ok && pins.demod;
      carrier_out <= gate_ok && pins.carrier;
      alert_b_out <= !alarm;
      chan_power_out <= cfg.chan_en;
      gain_red_out <= cfg.gain_red;
    end
  end
endmodule

// File: shared/oef_cfg.svh
// offsets, field positions, reset values and timing counts for the header filter
// assumes a 20 MHz system clock and a 32 kHz filter time base derived from it
`ifndef OEF_CFG_SVH
`define OEF_CFG_SVH

// ------------------------------------------------------------
// clocks
// ------------------------------------------------------------
`define OEF_CLK_HZ 20000000
`define OEF_CLK_NS 50
`define OEF_RC_HZ 32000
`define OEF_DIV_CYCLES (`OEF_CLK_HZ / `OEF_RC_HZ)
`define OEF_TICKS_PER_MS (`OEF_RC_HZ / 1000)

// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define OEF_AGC_SETTLE_US 3500
`define OEF_AGC_TICKS ((`OEF_AGC_SETTLE_US * `OEF_RC_HZ) / 1000000)
`define OEF_GAP_US 250
`define OEF_GAP_TICKS ((`OEF_GAP_US * `OEF_RC_HZ) / 1000000)
`define OEF_RESTART_GAP_US 250
`define OEF_RESTART_TICKS ((`OEF_RESTART_GAP_US * `OEF_RC_HZ) / 1000000)
`define OEF_ALARM_MS 32
`define OEF_ALARM_TICKS (`OEF_ALARM_MS * `OEF_TICKS_PER_MS)
`define OEF_DROP_NS 56000
`define OEF_DROP_CYCLES (`OEF_DROP_NS / `OEF_CLK_NS)

// ------------------------------------------------------------
// register map
// ------------------------------------------------------------
`define OEF_ADDR_CFG0 5'h00
`define OEF_ADDR_CFG1 5'h04
`define OEF_ADDR_GAIN 5'h08
`define OEF_ADDR_STATUS 5'h0C
`define OEF_ADDR_CTRL 5'h10
`define OEF_CFG0_RESET 9'h000
`define OEF_CFG1_RESET 1'b0
`define OEF_GAIN_RESET 12'h000
`define OEF_HSEL_LSB 7
`define OEF_LSEL_LSB 5
`define OEF_CHEN_LSB 1
`define OEF_GATE_BIT 7
`define OEF_ST_ALARM_BIT 0
`define OEF_ST_OPEN_BIT 1
`define OEF_ST_AGCF_BIT 5
`define OEF_ST_STATE_LSB 8
`define OEF_CTRL_SRST_BIT 0

`endif

// File: shared/oef_pkg.sv
// types shared by the header filter modules
// assumes oef_cfg.svh supplies the numeric constants
package oef_pkg;

  // filter sequencing
  typedef enum logic [2:0] {
    ST_STANDBY,
    ST_AGC,
    ST_GAP,
    ST_ARM,
    ST_HIGH,
    ST_LOW,
    ST_HOLDOFF,
    ST_OPEN
  } filt_state_t;

  // software-visible configuration
  typedef struct packed {
    logic [1:0] high_time_sel;
    logic [1:0] low_time_sel;
    logic [2:0] chan_en;
    logic strong_signal_gate;
    logic [11:0] gain_red;
  } oef_cfg_t;

  // front-end levels after synchronising
  typedef struct packed {
    logic demod;
    logic carrier;
    logic agc;
  } fe_pins_t;

endpackage

// File: rtl/rc_tick_gen.sv
// divider giving a one-cycle enable at the filter time base rate
// assumes one system clock and a synchronous active-low reset
`timescale 1ns/10ps
module rc_tick_gen #(
  parameter int DIV = 625
) (
  input wire logic clock_in,
  input wire logic rst_b_in,
  input wire logic restart_in,
  output logic tick_out
);
  localparam int CW = $clog2(DIV);
  localparam logic [CW-1:0] LAST = CW'(DIV - 1);

  logic [CW-1:0] count;
  logic [CW-1:0] next_count;
  logic wrap;

  // ------------------------------------------------------------
  // divider
  // ------------------------------------------------------------
  // restart aligns the time base to the soft reset, like a fresh oscillator
  assign wrap = (count == LAST);
  assign next_count = (restart_in || wrap) ? '0 : count + CW'(1);

  always_ff @(posedge clock_in) begin
    if (!rst_b_in) begin
      count <= '0;
      tick_out <= 1'b0;
    end else begin
      count <= next_count;
      tick_out <= wrap && !restart_in;
    end
  end
endmodule

// File: test/oef_monitor.sv
// concurrent checks on the header filter ports, bound into every filter instance
// assumes one 20 MHz clock domain and the synchronous active-low reset
`timescale 1ns/10ps
`include "oef_cfg.svh"
module oef_monitor (
  input wire logic clock_in,
  input wire logic rst_b_in,
  input wire logic [4:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire oef_pkg::fe_pins_t fe_in,
  input wire logic soft_reset_cmd_in,
  input wire logic [31:0] avs_readdata_out,
  input wire logic avs_waitrequest_out,
  input wire logic demod_data_out,
  input wire logic carrier_out,
  input wire logic alert_b_out,
  input wire logic [2:0] chan_power_out,
  input wire logic [11:0] gain_red_out
);
  import oef_pkg::*;
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rst_b_in);
  // ----
  // shadow of the written configuration
  // ----
  logic wr_ok;
  logic acc_ok;
  logic [2:0] chan_q;
  logic [11:0] gain_q;
  logic gate_q;
  // an access completes at the edge that sees waitrequest low
  assign wr_ok = avs_write_in && !avs_waitrequest_out;
  assign acc_ok = (avs_read_in || avs_write_in) && !avs_waitrequest_out;
  // shadow kept in step with the bus, reset with the design
  always_ff @(posedge clock_in) begin
    if (!rst_b_in) begin
      chan_q <= '0;
      gain_q <= '0;
      gate_q <= 1'b0;
    end else if (wr_ok) begin
      if (avs_address_in == `OEF_ADDR_CFG0) chan_q <= avs_writedata_in[3:1];
      if (avs_address_in == `OEF_ADDR_GAIN) gain_q <= avs_writedata_in[11:0];
      if (avs_address_in == `OEF_ADDR_CFG1) gate_q <= avs_writedata_in[7];
    end
  end
  // ----
  // properties
  // ----
  property p_bus;
    (avs_read_in || avs_write_in) && avs_waitrequest_out |=> !avs_waitrequest_out ##1 avs_waitrequest_out;
  endproperty
  a_bus: assert property (p_bus) else $error("bus wait state count wrong");
  property p_chan;
    wr_ok && avs_address_in == `OEF_ADDR_CFG0 |-> ##2 chan_power_out == chan_q;
  endproperty
  a_chan: assert property (p_chan) else $error("channel power differs from written enables");
  property p_gain;
    wr_ok && avs_address_in == `OEF_ADDR_GAIN |-> ##2 gain_red_out == gain_q;
  endproperty
  a_gain: assert property (p_gain) else $error("gain reduction differs from written value");
  property p_gate_block;
    (gate_q && !fe_in.agc) [*6] |-> !carrier_out && !demod_data_out;
  endproperty
  a_gate_block: assert property (p_gate_block) else $error("output seen while gated");
  property p_carrier_pass;
    (!gate_q && fe_in.carrier) [*6] |-> carrier_out;
  endproperty
  a_carrier_pass: assert property (p_carrier_pass) else $error("carrier missing with gate clear");
  property p_data_src;
    demod_data_out |-> $past(fe_in.demod, 3) || $past(fe_in.demod, 4) || $past(fe_in.demod, 5);
  endproperty
  a_data_src: assert property (p_data_src) else $error("data output high without demodulated high");
  property p_soft;
    soft_reset_cmd_in |-> ##6 !demod_data_out [*8];
  endproperty
  a_soft: assert property (p_soft) else $error("data output open after soft reset");
  property p_alarm_clear;
    acc_ok |-> ##[1:3] alert_b_out;
  endproperty
  a_alarm_clear: assert property (p_alarm_clear) else $error("alert not cleared by access");
  property p_agc_flag;
    fe_in.agc [*6] ##0 (avs_read_in && !avs_waitrequest_out && avs_address_in == `OEF_ADDR_STATUS)
      |-> avs_readdata_out[5];
  endproperty
  a_agc_flag: assert property (p_agc_flag) else $error("regulating flag clear while agc high");
  c_open: cover property (demod_data_out);
  c_gated: cover property (gate_q && carrier_out);
  c_soft: cover property (soft_reset_cmd_in);
endmodule
bind output_enable_header_filter oef_monitor u_mon (.clock_in(clock_in), .rst_b_in(rst_b_in),
  .avs_address_in(avs_address_in), .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
  .avs_writedata_in(avs_writedata_in), .fe_in(fe_in), .soft_reset_cmd_in(soft_reset_cmd_in),
  .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
  .demod_data_out(demod_data_out), .carrier_out(carrier_out), .alert_b_out(alert_b_out),
  .chan_power_out(chan_power_out), .gain_red_out(gain_red_out));

// File: test/fe_source.sv
// stand-in for the sender and analog front end: envelope, carrier and agc level
// assumes the bench calls its task right after a rising clock edge
`timescale 1ns/10ps
module fe_source (
  input wire logic clock_in,
  output oef_pkg::fe_pins_t fe_out
);
  import oef_pkg::*;
  logic env = 1'b0;
  logic agc = 1'b0;
  int ph = 0;
  initial fe_out = '0;
  // carrier only under the envelope, never broken during a high; no carrier reads as 0
  always @(posedge clock_in) begin
    ph <= (ph == 79) ? 0 : ph + 1;
    fe_out.carrier <= env ? (fe_out.carrier ^ (ph == 79)) : 1'b0;
    fe_out.demod <= env;
    fe_out.agc <= agc;
  end
  // set envelope and agc level, then let n clocks pass
  task automatic level(input logic v, input logic a, input int n);
    env <= v;
    agc <= a;
    repeat (n) @(posedge clock_in);
  endtask
endmodule

// File: test/tb_top.sv
// bench for the header filter: bus tasks, scripted header traffic, checks
// assumes package, design, monitor and source model are compiled first
`timescale 1ns/10ps
`include "oef_cfg.svh"
module tb_top;
  import oef_pkg::*;
  logic clock_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic [4:0] avs_address_in = '0;
  logic avs_read_in = 1'b0;
  logic avs_write_in = 1'b0;
  logic [31:0] avs_writedata_in = '0;
  logic soft_reset_cmd_in = 1'b0;
  fe_pins_t fe;
  logic [31:0] avs_readdata_out;
  logic avs_waitrequest_out;
  logic demod_data_out;
  logic carrier_out;
  logic alert_b_out;
  logic [2:0] chan_power_out;
  logic [11:0] gain_red_out;
  logic [31:0] q;
  logic [1:0] s;
  int errors = 0;
  int cmp_count = 0;
  localparam int TICK = `OEF_DIV_CYCLES;
  output_enable_header_filter u_dut (.clock_in(clock_in), .rst_b_in(rst_b_in), .avs_address_in(avs_address_in),
    .avs_read_in(avs_read_in), .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in), .fe_in(fe),
    .soft_reset_cmd_in(soft_reset_cmd_in), .avs_readdata_out(avs_readdata_out),
    .avs_waitrequest_out(avs_waitrequest_out), .demod_data_out(demod_data_out), .carrier_out(carrier_out),
    .alert_b_out(alert_b_out), .chan_power_out(chan_power_out), .gain_red_out(gain_red_out));
  fe_source u_src (.clock_in(clock_in), .fe_out(fe));
  // ----
  // tasks
  // ----
  initial begin
    forever #25 clock_in = ~clock_in;
  end
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  // one bus access; request held until waitrequest is sampled low, then an idle edge
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d, output logic [31:0] r);
    int n;
    n = 0;
    avs_address_in <= a;
    avs_writedata_in <= d;
    avs_write_in <= wr;
    avs_read_in <= !wr;
    @(posedge clock_in);
    while (avs_waitrequest_out !== 1'b0 && n < 100) begin
      n++;
      @(posedge clock_in);
    end
    if (n == 100) errors++;
    r = avs_readdata_out;
    avs_read_in <= 1'b0;
    avs_write_in <= 1'b0;
    @(posedge clock_in);
  endtask
  task automatic rd(input logic [4:0] a, input logic [31:0] exp, input string what);
    bus(1'b0, a, 32'h0000_0000, q);
    chk(what, exp, q);
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    bus(1'b1, a, d, q);
  endtask
  // gather what the carrier and data outputs showed over n clocks
  task automatic watch(input int n, output logic [1:0] seen);
    seen = 2'b00;
    repeat (n) begin
      @(posedge clock_in);
      seen = seen | {carrier_out, demod_data_out};
    end
  endtask
  // poll the state field with a bounded number of reads
  task automatic wait_state(input filt_state_t st, input int polls);
    int i;
    for (i = 0; i < polls; i++) begin
      bus(1'b0, `OEF_ADDR_STATUS, 32'h0000_0000, q);
      if (q[10:8] === st) break;
      repeat (300) @(posedge clock_in);
    end
    chk("state", {29'h0, st}, {29'h0, q[10:8]});
  endtask
  task automatic complete_run();
    $display("comparisons %0d errors %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // ----
  // watchdog: the scripted run needs about 125000 clocks
  // ----
  initial begin
    repeat (160000) @(posedge clock_in);
    errors++;
    complete_run();
  end
  // ----
  // scripted run
  // ----
  initial begin
    repeat (3) @(posedge clock_in);
    rst_b_in <= 1'b1;
    @(posedge clock_in);
    rd(`OEF_ADDR_CFG0, 32'h0000_0000, "cfg0");
    rd(`OEF_ADDR_GAIN, 32'h0000_0000, "gain");
    rd(`OEF_ADDR_STATUS, 32'h0000_0000, "status");
    chk("alert", 32'h1, {31'h0, alert_b_out});
    wr(`OEF_ADDR_CFG0, 32'h0000_008A);
    rd(`OEF_ADDR_CFG0, 32'h0000_008A, "cfg0");
    chk("chan_power", 32'h5, {29'h0, chan_power_out});
    wr(`OEF_ADDR_GAIN, 32'h0000_0A53);
    @(posedge clock_in);
    chk("gain_red", 32'h0000_0A53, {20'h0, gain_red_out});
    // refused places: unmapped word, read-only status, write-only control
    wr(5'h14, 32'hFFFF_FFFF);
    rd(5'h14, 32'h0000_0000, "unmapped");
    wr(`OEF_ADDR_STATUS, 32'hFFFF_FFFF);
    rd(`OEF_ADDR_STATUS, 32'h0000_0000, "status ro");
    rd(`OEF_ADDR_CTRL, 32'h0000_0000, "ctrl");
    wr(`OEF_ADDR_CTRL, 32'h0000_0001);
    rd(`OEF_ADDR_CFG0, 32'h0000_008A, "cfg0 kept");
    u_src.level(1'b0, 1'b1, 10);
    rd(`OEF_ADDR_STATUS, 32'h0000_0020, "agc flag");
    // envelope rises here and starts agc settling; gate checks run meanwhile
    u_src.level(1'b1, 1'b0, 0);
    watch(200, s);
    chk("carrier free", 32'h1, {31'h0, s[1]});
    wr(`OEF_ADDR_CFG1, 32'h0000_0080);
    watch(300, s);
    chk("gated", 32'h0, {30'h0, s});
    u_src.level(1'b1, 1'b1, 0);
    watch(300, s);
    chk("carrier agc", 32'h1, {31'h0, s[1]});
    wait_state(ST_GAP, 400);
    u_src.level(1'b0, 1'b1, 0);
    wait_state(ST_ARM, 40);
    chk("closed", 32'h0, {31'h0, demod_data_out});
    // a 4 tick high is too short and drops back to arm; the next rise starts a fresh high
    u_src.level(1'b1, 1'b1, 4 * TICK);
    u_src.level(1'b0, 1'b1, 20);
    rd(`OEF_ADDR_STATUS, 32'h0000_0320, "short high");
    u_src.level(1'b0, 1'b1, 2 * TICK);
    u_src.level(1'b1, 1'b1, 20);
    rd(`OEF_ADDR_STATUS, 32'h0000_0420, "fresh high");
    u_src.level(1'b1, 1'b1, 34 * TICK);
    u_src.level(1'b0, 1'b1, 20);
    rd(`OEF_ADDR_STATUS, 32'h0000_0520, "low");
    u_src.level(1'b0, 1'b1, 34 * TICK);
    u_src.level(1'b1, 1'b1, 20);
    rd(`OEF_ADDR_STATUS, 32'h0000_0722, "open");
    u_src.level(1'b1, 1'b1, 100);
    chk("data high", 32'h1, {31'h0, demod_data_out});
    u_src.level(1'b0, 1'b1, 100);
    chk("data low", 32'h0, {31'h0, demod_data_out});
    u_src.level(1'b1, 1'b0, 100);
    chk("data gated", 32'h0, {31'h0, demod_data_out});
    u_src.level(1'b1, 1'b1, 100);
    chk("data again", 32'h1, {31'h0, demod_data_out});
    soft_reset_cmd_in <= 1'b1;
    @(posedge clock_in);
    soft_reset_cmd_in <= 1'b0;
    repeat (20) @(posedge clock_in);
    chk("after soft reset", 32'h0, {31'h0, demod_data_out});
    bus(1'b0, `OEF_ADDR_STATUS, 32'h0000_0000, q);
    chk("open flag", 32'h0, {31'h0, q[1]});
    complete_run();
  end
endmodule
